// >>> rtl/pc_vec_pkg.sv
// Constants for the program counter and vector block
package pc_vec_pkg;
    localparam int          PC_W          = 21;
    localparam logic [20:0] RESET_VECTOR  = 21'h000000;
    localparam logic [20:0] HIGH_VECTOR   = 21'h000008;
    localparam logic [20:0] LOW_VECTOR    = 21'h000018;
    localparam logic [20:0] PC_STEP       = 21'h000002;
    localparam logic [20:0] FLASH_64K     = 21'h010000;
    localparam logic [20:0] FLASH_128K    = 21'h020000;
    localparam logic [20:0] CFG_SPAN      = 21'h000008;
    localparam int          CFG_WORDS     = 3;
    localparam int          STACK_DEPTH   = 31;
    localparam logic [15:0] NOP_WORD      = 16'h0000;
    localparam logic [7:0]  LATCH_RESET   = 8'h00;
    localparam logic [4:0]  SP_RESET      = 5'h00;
    localparam logic [4:0]  SP_TOP        = 5'h1F;
    localparam logic [15:0] CFG_RESET     = 16'hFFFF;
    typedef enum logic [1:0] {LD_IDLE, LD_FETCH, LD_DONE} cfg_state_t;
endpackage

// >>> rtl/program_counter_and_vectors.sv
// Program counter, latches, vectors, return stack push and setup word load
// How it works
// - Twenty-one bit counter, two megabyte space
// - Fetch beyond flash returns zero NOP
// - Flash size is 64K or 128K
// - Fetch and data on separate buses
// - Reset loads counter with zero vector
// - High interrupt 0008h, low 0018h
// - Three of the top four flash words copied at reset
// - Ascending words, three used, fourth reserved
// - Setup words at FFF8h or 1FFF8h
// - Low byte readable and writable
// - Bits 15..8 only via high latch
// - Bits 20..16 only via upper latch
// - Low byte write loads counter from both latches
// - Low byte read captures upper bytes
// - Bit zero always held at zero
// - Sequential advance by two
// - Jumps load target, ignore latches
// - Interrupt wake pushes counter on stack
// - Interrupt wake then loads vector
// - Push increments pointer, then writes
`timescale 1ns/1ps
`default_nettype none
module program_counter_and_vectors #(
    parameter bit LARGE_FLASH = 1'b0
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        step_i,
    input  wire logic        jump_i,
    input  wire logic [20:0] jump_target_i,
    input  wire logic        push_call_i,
    input  wire logic        irq_high_i,
    input  wire logic        irq_low_i,
    input  wire logic        wake_i,
    input  wire logic        high_priority_global_enable_i,
    input  wire logic        low_priority_global_enable_i,
    input  wire logic        low_wr_i,
    input  wire logic        low_rd_i,
    input  wire logic [7:0]  data_wr_i,
    input  wire logic        high_latch_wr_i,
    input  wire logic        upper_latch_wr_i,
    input  wire logic [15:0] flash_data_i,
    input  wire logic        data_req_i,
    input  wire logic [7:0]  data_addr_i,
    output logic [20:0]      fetch_addr_o,
    output logic [15:0]      fetch_word_o,
    output logic [7:0]       pc_low_byte_o,
    output logic [7:0]       pc_high_latch_o,
    output logic [7:0]       pc_upper_latch_o,
    output logic [20:0]      top_of_stack_o,
    output logic [4:0]       return_stack_pointer_o,
    output logic             stack_full_o,
    output logic [15:0]      first_setup_word_o,
    output logic [15:0]      second_setup_word_o,
    output logic [15:0]      third_setup_word_o,
    output logic             setup_ready_o,
    output logic             data_ack_o,
    output logic [7:0]       data_addr_o
);
    // ****************************************
    // Reset release and flash geometry
    // ****************************************
    logic                    rst_meta;
    logic                    rst_sync;
    logic [20:0]             flash_end;
    logic [20:0]             cfg_base;
    logic [20:0]             instruction_pointer;
    logic [20:0]             next_pc;
    logic [20:0]             stack_mem [1:pc_vec_pkg::STACK_DEPTH];
    logic [4:0]              sp;
    logic                    vector_take;
    logic [20:0]             vector_addr;
    pc_vec_pkg::cfg_state_t  cfg_state;
    logic [1:0]              cfg_idx;
    logic [20:0]             cfg_addr;
    logic                    load_last;
    logic                    push_now;
    logic [20:0]             push_value;

    // Two flops so release is clean to the clock
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign flash_end = LARGE_FLASH ? pc_vec_pkg::FLASH_128K : pc_vec_pkg::FLASH_64K;
    // setup words sit in the last eight bytes
    assign cfg_base  = flash_end - pc_vec_pkg::CFG_SPAN;

    // ****************************************
    // Interrupt vector selection
    // ****************************************
    // high priority wins when both arrive
    assign vector_addr = irq_high_i ? pc_vec_pkg::HIGH_VECTOR : pc_vec_pkg::LOW_VECTOR;
    // wake counts only with a global enable set
    assign vector_take = (irq_high_i || irq_low_i) && (!wake_i
                         || high_priority_global_enable_i || low_priority_global_enable_i);

    // Next counter value, priority vector > jump > low write > step
    always_comb
    begin
        next_pc = instruction_pointer;
        if (!setup_ready_o)
            // Controls refused until the setup words are in
            next_pc = instruction_pointer;
        else if (vector_take)
            next_pc = vector_addr;
        else if (jump_i)
            next_pc = jump_target_i;
        else if (low_wr_i)
            // latches join the written low byte
            next_pc = {pc_upper_latch_o[4:0], pc_high_latch_o, data_wr_i};
        else if (step_i)
            next_pc = instruction_pointer + pc_vec_pkg::PC_STEP;
        next_pc[0] = 1'b0;
    end

    // ****************************************
    // Program counter register
    // ****************************************
    // counter held at reset vector while setup loads
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            instruction_pointer <= pc_vec_pkg::RESET_VECTOR;
        else if (!rst_sync || !setup_ready_o)
            instruction_pointer <= pc_vec_pkg::RESET_VECTOR;
        else
            instruction_pointer <= next_pc;
    end

    // ****************************************
    // Latches and low byte view
    // ****************************************
    // latches only store; read captures
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_high_latch_o  <= pc_vec_pkg::LATCH_RESET;
            pc_upper_latch_o <= pc_vec_pkg::LATCH_RESET;
        end
        else if (low_rd_i)
        begin
            pc_high_latch_o  <= instruction_pointer[15:8];
            pc_upper_latch_o <= {3'b000, instruction_pointer[20:16]};
        end
        else
        begin
            if (high_latch_wr_i)
                pc_high_latch_o <= data_wr_i;
            if (upper_latch_wr_i)
                pc_upper_latch_o <= {3'b000, data_wr_i[4:0]};
        end
    end

    // low byte readable copy of the counter
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pc_low_byte_o <= 8'h00;
        else
            pc_low_byte_o <= next_pc[7:0];
    end

    // ****************************************
    // Fetch path
    // ****************************************
    // beyond flash reads as NOP; setup area served from flash too
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fetch_addr_o <= pc_vec_pkg::RESET_VECTOR;
            fetch_word_o <= pc_vec_pkg::NOP_WORD;
        end
        else
        begin
            fetch_addr_o <= (setup_ready_o || load_last) ? next_pc : cfg_addr;
            fetch_word_o <= (fetch_addr_o < flash_end) ? flash_data_i
                                                       : pc_vec_pkg::NOP_WORD;
        end
    end

    // data side has its own port, never stalls fetch
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_ack_o  <= 1'b0;
            data_addr_o <= 8'h00;
        end
        else
        begin
            data_ack_o  <= data_req_i;
            data_addr_o <= data_addr_i;
        end
    end

    // ****************************************
    // Return stack push
    // ****************************************
    // Push request and the value it saves
    assign push_now   = rst_sync && setup_ready_o && (vector_take || push_call_i);
    assign push_value = (push_call_i && !vector_take)
                        ? instruction_pointer + pc_vec_pkg::PC_STEP
                        : instruction_pointer;

    // pointer first, then write; saturates at the top
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sp           <= pc_vec_pkg::SP_RESET;
            stack_full_o <= 1'b0;
        end
        else if (rst_sync && setup_ready_o && (vector_take || push_call_i))
        begin
            if (sp != pc_vec_pkg::SP_TOP)
                sp <= sp + 5'h01;
            if (sp >= pc_vec_pkg::SP_TOP - 5'h01)
                stack_full_o <= 1'b1;
        end
    end

    // store the return address in the new slot
    always_ff @(posedge clk_sys_i)
    begin
        if (push_now && sp != pc_vec_pkg::SP_TOP)
            stack_mem[sp + 5'h01] <= push_value;
    end

    // Top of stack and pointer views
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            top_of_stack_o         <= pc_vec_pkg::RESET_VECTOR;
            return_stack_pointer_o <= pc_vec_pkg::SP_RESET;
        end
        else if (push_now && sp != pc_vec_pkg::SP_TOP)
        begin
            // Views move with the push so software sees it at once
            return_stack_pointer_o <= sp + 5'h01;
            top_of_stack_o         <= push_value;
        end
        else
        begin
            return_stack_pointer_o <= sp;
            top_of_stack_o <= (sp == pc_vec_pkg::SP_RESET) ? pc_vec_pkg::RESET_VECTOR
                                                           : stack_mem[sp];
        end
    end

    // ****************************************
    // Setup word copy after reset
    // ****************************************
    // three words read upward, fourth skipped
    assign cfg_addr = cfg_base + {18'h00000, cfg_idx, 1'b0};
    // Last word lands now: fetch returns to the reset vector with it
    assign load_last = (cfg_state == pc_vec_pkg::LD_FETCH) && (fetch_addr_o == cfg_addr)
                       && (cfg_idx == 2'(pc_vec_pkg::CFG_WORDS - 1));

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_state           <= pc_vec_pkg::LD_IDLE;
            cfg_idx             <= 2'b00;
            setup_ready_o       <= 1'b0;
            first_setup_word_o  <= pc_vec_pkg::CFG_RESET;
            second_setup_word_o <= pc_vec_pkg::CFG_RESET;
            third_setup_word_o  <= pc_vec_pkg::CFG_RESET;
        end
        else if (rst_sync)
        begin
            unique case (cfg_state)
                pc_vec_pkg::LD_IDLE:
                    // Address goes out this cycle, data back one later
                    cfg_state <= pc_vec_pkg::LD_FETCH;
                pc_vec_pkg::LD_FETCH:
                begin
                    // Wait for the address to reach flash before sampling
                    if (fetch_addr_o == cfg_addr)
                    begin
                        unique case (cfg_idx)
                            2'd0:    first_setup_word_o  <= flash_data_i;
                            2'd1:    second_setup_word_o <= flash_data_i;
                            default: third_setup_word_o  <= flash_data_i;
                        endcase
                        if (cfg_idx == 2'(pc_vec_pkg::CFG_WORDS - 1))
                        begin
                            cfg_state     <= pc_vec_pkg::LD_DONE;
                            setup_ready_o <= 1'b1;
                        end
                        else
                            cfg_idx <= cfg_idx + 2'b01;
                    end
                end
                pc_vec_pkg::LD_DONE:
                    cfg_state <= pc_vec_pkg::LD_DONE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> tb/flash_model.sv
// Program flash model answering the block's fetch addresses
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
    parameter bit LARGE_FLASH = 1'b0
) (
    input  wire logic        clk_sys_i,
    input  wire logic [20:0] fetch_addr_i,
    output logic [15:0]      flash_data_o
);
    // ********************
    // Flash contents
    // ********************
    initial flash_data_o = 16'h0000;
    // size and word order
    // Past the cells the lines wander, so a zero there must come from the block
    always @(negedge clk_sys_i)
    begin
        if (fetch_addr_i < (LARGE_FLASH ? pc_vec_pkg::FLASH_128K : pc_vec_pkg::FLASH_64K))
            flash_data_o <= fetch_addr_i[16:1] ^ 16'hC35A;
        else
            flash_data_o <= ~flash_data_o;
    end
endmodule
`default_nettype wire

// >>> tb/program_counter_and_vectors_assertions.sv
// Port checker for the program counter and vector block
`timescale 1ns/1ps
`default_nettype none
module program_counter_and_vectors_assertions #(
    parameter bit LARGE_FLASH = 1'b0
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        step_i,
    input wire logic        jump_i,
    input wire logic [20:0] jump_target_i,
    input wire logic        push_call_i,
    input wire logic        irq_high_i,
    input wire logic        irq_low_i,
    input wire logic        wake_i,
    input wire logic        high_priority_global_enable_i,
    input wire logic        low_priority_global_enable_i,
    input wire logic        low_wr_i,
    input wire logic        low_rd_i,
    input wire logic [7:0]  data_wr_i,
    input wire logic        high_latch_wr_i,
    input wire logic        upper_latch_wr_i,
    input wire logic        data_req_i,
    input wire logic [7:0]  data_addr_i,
    input wire logic [20:0] fetch_addr_o,
    input wire logic [15:0] fetch_word_o,
    input wire logic [7:0]  pc_low_byte_o,
    input wire logic [7:0]  pc_high_latch_o,
    input wire logic [7:0]  pc_upper_latch_o,
    input wire logic [20:0] top_of_stack_o,
    input wire logic [4:0]  return_stack_pointer_o,
    input wire logic        setup_ready_o,
    input wire logic        data_ack_o,
    input wire logic [7:0]  data_addr_o
);
    // ********************
    // Helpers and checks
    // ********************
    logic        irq_take;
    logic        moves;
    logic [20:0] merged;
    logic [15:0] upper_bytes;
    logic [20:0] lim;
    // A wake-up without any enable must not vector
    assign irq_take = (irq_high_i | irq_low_i)
        & (~wake_i | high_priority_global_enable_i | low_priority_global_enable_i);
    assign moves = step_i | jump_i | low_wr_i | irq_take;
    assign merged = {pc_upper_latch_o[4:0], pc_high_latch_o, data_wr_i[7:1], 1'b0};
    assign upper_bytes = {3'b000, fetch_addr_o[20:16], fetch_addr_o[15:8]};
    assign lim = LARGE_FLASH ? pc_vec_pkg::FLASH_128K : pc_vec_pkg::FLASH_64K;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_step_adds_two: assert property (setup_ready_o && step_i && !jump_i && !low_wr_i
        && !irq_take |=> fetch_addr_o == $past(fetch_addr_o) + pc_vec_pkg::PC_STEP)
        else $error("step did not advance by two");
    a_jump_target: assert property (setup_ready_o && jump_i && !irq_take
        |=> fetch_addr_o == ($past(jump_target_i) & 21'h1FFFFE)) else $error("jump target lost");
    a_high_vector: assert property (setup_ready_o && irq_take && irq_high_i
        |=> fetch_addr_o == pc_vec_pkg::HIGH_VECTOR) else $error("high vector wrong");
    a_low_vector: assert property (setup_ready_o && irq_take && !irq_high_i
        |=> fetch_addr_o == pc_vec_pkg::LOW_VECTOR) else $error("low vector wrong");
    a_irq_push: assert property (setup_ready_o && irq_take && return_stack_pointer_o != 5'h1F
        |=> top_of_stack_o == $past(fetch_addr_o)) else $error("interrupt push wrong");
    a_call_push: assert property (setup_ready_o && push_call_i && !irq_take
        && return_stack_pointer_o != 5'h1F |=> return_stack_pointer_o ==
        $past(return_stack_pointer_o) + 5'h01 && top_of_stack_o == $past(fetch_addr_o)
        + pc_vec_pkg::PC_STEP) else $error("call push wrong");
    a_low_write_merge: assert property (setup_ready_o && low_wr_i && !jump_i && !irq_take
        |=> fetch_addr_o == $past(merged)) else $error("low byte write merge wrong");
    a_read_capture: assert property (setup_ready_o && low_rd_i
        |=> {pc_upper_latch_o, pc_high_latch_o} == $past(upper_bytes)) else $error("latch capture");
    a_latch_only: assert property (setup_ready_o && (high_latch_wr_i || upper_latch_wr_i)
        && !moves |=> $stable(fetch_addr_o)) else $error("latch write moved counter");
    a_low_mirror: assert property (setup_ready_o
        |-> pc_low_byte_o == fetch_addr_o[7:0] && !fetch_addr_o[0]) else $error("low byte wrong");
    a_beyond_zero: assert property ((setup_ready_o && fetch_addr_o >= lim) [*2]
        |=> fetch_word_o == pc_vec_pkg::NOP_WORD) else $error("fetch beyond flash not zero");
    a_data_echo: assert property (data_req_i
        |=> data_ack_o && data_addr_o == $past(data_addr_i)) else $error("data port lost");
endmodule
bind program_counter_and_vectors program_counter_and_vectors_assertions
    #(.LARGE_FLASH(LARGE_FLASH)) checker_inst (.*);
`default_nettype wire

// >>> tb/tb_program_counter_and_vectors.sv
// Self-checking bench for the program counter and vector block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_program_counter_and_vectors;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, step_i = 1'b0, jump_i = 1'b0, push_call_i = 1'b0;
    logic irq_high_i = 1'b0, irq_low_i = 1'b0, wake_i = 1'b0, low_wr_i = 1'b0, low_rd_i = 1'b0;
    logic high_priority_global_enable_i = 1'b0, low_priority_global_enable_i = 1'b0;
    logic high_latch_wr_i = 1'b0, upper_latch_wr_i = 1'b0, data_req_i = 1'b0;
    logic stack_full_o, setup_ready_o, data_ack_o;
    logic [20:0] jump_target_i = '0, fetch_addr_o, top_of_stack_o;
    logic [7:0] data_wr_i = '0, data_addr_i = '0, pc_low_byte_o, pc_high_latch_o;
    logic [7:0] pc_upper_latch_o, data_addr_o;
    logic [15:0] flash_data_i, fetch_word_o, first_setup_word_o, second_setup_word_o;
    logic [15:0] third_setup_word_o;
    logic [4:0] return_stack_pointer_o;
    int failures = 0;
    int check_count = 0;
    program_counter_and_vectors #(.LARGE_FLASH(1'b0)) dut (.*);
    flash_model #(.LARGE_FLASH(1'b0)) flash (.clk_sys_i(clk_sys_i), .fetch_addr_i(fetch_addr_o),
        .flash_data_o(flash_data_i));
    // ********************
    // Helpers and scenarios
    // ********************
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task automatic tick(input int n = 1);
        repeat (n) @(negedge clk_sys_i);
    endtask
    function automatic logic [15:0] word_at(input logic [20:0] a);
        return a[16:1] ^ 16'hC35A;
    endfunction
    // Reset, wait for the setup words, check the reset state
    task automatic t_boot;
        int n;
        rst_n_i = 1'b0;
        tick(12);
        rst_n_i = 1'b1;
        for (n = 0; n < 200 && setup_ready_o !== 1'b1; n++) tick();
        `CHK(fetch_addr_o, pc_vec_pkg::RESET_VECTOR)
        `CHK(first_setup_word_o, word_at(21'h00FFF8))
        `CHK(second_setup_word_o, word_at(21'h00FFFA))
        `CHK(third_setup_word_o, word_at(21'h00FFFC))
        `CHK({stack_full_o, return_stack_pointer_o}, 6'h00)
    endtask
    // Steps, latch loads, merged low write, fetch past flash
    task automatic t_latch;
        step_i = 1'b1;
        tick(3);
        step_i = 1'b0;
        `CHK(fetch_addr_o, 21'h000006)
        data_wr_i = 8'h12;
        high_latch_wr_i = 1'b1;
        tick();
        `CHK(fetch_word_o, word_at(21'h000006))
        high_latch_wr_i = 1'b0;
        upper_latch_wr_i = 1'b1;
        data_wr_i = 8'h01;
        tick();
        upper_latch_wr_i = 1'b0;
        `CHK({pc_upper_latch_o, pc_high_latch_o, fetch_addr_o}, {8'h01, 8'h12, 21'h000006})
        low_wr_i = 1'b1;
        data_wr_i = 8'h35;
        tick();
        low_wr_i = 1'b0;
        `CHK(fetch_addr_o, 21'h011234)
        tick(3);
        `CHK(fetch_word_o, 16'h0000)
    endtask
    // Jump ignores latches, then a low read refills them
    task automatic t_jump;
        jump_target_i = 21'h0ABCDF;
        jump_i = 1'b1;
        tick();
        jump_i = 1'b0;
        `CHK({pc_high_latch_o, fetch_addr_o}, {8'h12, 21'h0ABCDE})
        low_rd_i = 1'b1;
        tick();
        low_rd_i = 1'b0;
        `CHK({pc_upper_latch_o, pc_high_latch_o}, 16'h0ABC)
    endtask
    // Interrupts, gated wake-ups, a call push, then the stack fills
    task automatic t_irq;
        irq_high_i = 1'b1;
        tick();
        irq_high_i = 1'b0;
        `CHK({top_of_stack_o, fetch_addr_o}, {21'h0ABCDE, pc_vec_pkg::HIGH_VECTOR})
        irq_low_i = 1'b1;
        tick();
        irq_low_i = 1'b0;
        `CHK(fetch_addr_o, pc_vec_pkg::LOW_VECTOR)
        wake_i = 1'b1;
        irq_high_i = 1'b1;
        tick();
        `CHK({return_stack_pointer_o, fetch_addr_o}, 26'h0400018)
        low_priority_global_enable_i = 1'b1;
        tick();
        {wake_i, irq_high_i, low_priority_global_enable_i} = 3'h0;
        `CHK({return_stack_pointer_o, fetch_addr_o}, 26'h0600008)
        push_call_i = 1'b1;
        data_req_i = 1'b1;
        data_addr_i = 8'hA5;
        tick();
        data_req_i = 1'b0;
        `CHK({data_ack_o, data_addr_o, top_of_stack_o}, {1'b1, 8'hA5, 21'h00000A})
        tick(28);
        push_call_i = 1'b0;
        `CHK({stack_full_o, return_stack_pointer_o}, 6'h3F)
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        t_boot();
        t_latch();
        t_jump();
        t_irq();
        t_boot();
        give_verdict();
    end
    // Watchdog well beyond the hundred or fewer cycles the run needs
    initial
    begin
        #100us;
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
